// ### servo_sel_map.svh
// Register offsets, field positions, reset values and codes of the output selector block
`ifndef SERVO_SEL_MAP_SVH
`define SERVO_SEL_MAP_SVH
`define OFS_CTRL        8'h00
`define OFS_OUTSEL      8'h04
`define OFS_MONSEL      8'h08
`define OFS_FFGAIN      8'h0C
`define OFS_STATUS      8'h10
`define OFS_ERRCODE     8'h14
`define OFS_IRQ_STAT    8'h18
`define OFS_IRQ_MASK    8'h1C
`define CTRL_SPEED_BIT  0
`define CTRL_NOMOTOR    1
`define CTRL_HOME_SEL   2
`define CTRL_ABS_SYS    3
`define CTRL_HIST_CLR   4
`define CTRL_CABLE_4W   5
`define CTRL_RESET      6'h00
`define OUTSEL_RESET    6'h00
`define MON_RESET       4'h0
`define MON_MAX         4'hD
`define MON_ABS_LO      4'hA
`define MON_ABS_HI      4'hC
`define FFGAIN_RESET    7'h00
`define FFGAIN_MAX      7'h64
`define ERR_ENC1        16'h2016
`define ERR_ENC2        16'h2020
`define IRQ_ENC_ERR     0
`define IRQ_GAIN_REJ    1
`define IRQ_SEL_BAD     2
`define IRQ_HIST_DONE   3
`define IRQ_MON_REJ     4
`define SEL_OFF         6'h00
`define SEL_READY       6'h02
`define SEL_TROUBLE     6'h03
`define SEL_INPOS       6'h04
`define SEL_BRAKE       6'h05
`define SEL_DYNBRK      6'h06
`define SEL_TLIM        6'h07
`define SEL_WARN        6'h08
`define SEL_BATT        6'h09
`define SEL_SPEED       6'h0A
`define SEL_ZSPD        6'h0C
`define SEL_VGAIN       6'h0F
`define SEL_ABSLOST     6'h11
`endif

// ### servo_sel_pkg.sv
// Types shared by the output selector block
package servo_sel_pkg;
    typedef struct packed {
        logic ready;
        logic trouble_flag;
        logic in_position_flag;
        logic brake_interlock;
        logic external_dyn_brake;
        logic torque_limiting_flag;
        logic warning_flag;
        logic battery_warning_flag;
        logic speed_reached_flag;
        logic zero_speed_flag;
        logic variable_gain_active;
        logic abs_position_lost;
    } status_s;
    typedef struct packed {
        logic [15:0] accel_time;
        logic [15:0] eff_torque;
        logic [15:0] peak_load;
        logic [15:0] regen_ratio;
    } load_s;
    typedef enum logic [1:0] {
        ST_INIT,
        ST_ERASE,
        ST_RUN
    } init_e;
endpackage

// ### servo_output_signal_selector.sv
// Output signal selector with monitor select, home condition, motor-less mode and alarm history clear
`include "servo_sel_map.svh"
module servo_output_signal_selector (
    input  wire logic                   ref_clk_i,
    input  wire logic                   rst_n_i,
    input  wire logic [7:0]             addr_i,
    input  wire logic [31:0]            wdata_i,
    input  wire logic                   wr_i,
    input  wire logic                   rd_i,
    output logic      [31:0]            rdata_o,
    input  wire servo_sel_pkg::status_s status_i,
    input  wire servo_sel_pkg::load_s   load_i,
    input  wire logic [15:0]            motor_speed_i,
    input  wire logic [15:0]            speed_cmd_i,
    input  wire logic                   index_pulse_i,
    input  wire logic                   cable_4wire_i,
    input  wire logic                   hist_clr_stored_i,
    output logic                        out_pin_o,
    output logic [3:0]                  mon1_sel_o,
    output logic [3:0]                  mon2_sel_o,
    output logic [6:0]                  ffgain_o,
    output logic                        home_allowed_o,
    output logic                        enc_err1_o,
    output logic                        enc_err2_o,
    output logic                        hist_erase_o,
    output logic                        hist_clr_flag_o,
    output logic [15:0]                 speed_disp_o,
    output servo_sel_pkg::load_s        load_disp_o,
    output logic                        irq_o
);

    // ==========================================================
    // Functions
    function automatic logic mon_ok(input logic [3:0] code, input logic abs_sys);
        mon_ok = (code <= `MON_MAX) && (abs_sys || code < `MON_ABS_LO || code > `MON_ABS_HI);
    endfunction

    function automatic logic sel_pick(input logic [5:0] code, input logic speed_mode,
                                      input servo_sel_pkg::status_s s, output logic ok);
        ok = 1'b1;
        sel_pick = 1'b0;
        if (code == `SEL_OFF) begin
            sel_pick = 1'b0;
        end else if (code == `SEL_READY) begin
            sel_pick = s.ready;
        end else if (code == `SEL_TROUBLE) begin
            sel_pick = s.trouble_flag;
        end else if (code == `SEL_INPOS) begin
            sel_pick = !speed_mode && s.in_position_flag;
        end else if (code == `SEL_BRAKE) begin
            sel_pick = s.brake_interlock;
        end else if (code == `SEL_DYNBRK) begin
            sel_pick = s.external_dyn_brake;
        end else if (code == `SEL_TLIM) begin
            sel_pick = s.torque_limiting_flag;
        end else if (code == `SEL_WARN) begin
            sel_pick = s.warning_flag;
        end else if (code == `SEL_BATT) begin
            sel_pick = s.battery_warning_flag;
        end else if (code == `SEL_SPEED) begin
            sel_pick = speed_mode && s.speed_reached_flag;
        end else if (code == `SEL_ZSPD) begin
            sel_pick = s.zero_speed_flag;
        end else if (code == `SEL_VGAIN) begin
            sel_pick = s.variable_gain_active;
        end else if (code == `SEL_ABSLOST) begin
            sel_pick = !speed_mode && s.abs_position_lost;
        end else begin
            ok = 1'b0;
        end
    endfunction

    // ==========================================================
    // Registers
    logic [5:0]                  ctrl_reg;
    logic [5:0]                  outsel_reg;
    logic [3:0]                  mon1_reg;
    logic [3:0]                  mon2_reg;
    logic [6:0]                  ffgain_reg;
    logic [4:0]                  irq_stat_reg;
    logic [4:0]                  irq_mask_reg;
    logic [4:0]                  irq_set;
    logic                        zseen_reg;
    logic                        sel_bad;
    logic                        sel_val;
    logic                        sel_bad_reg;
    logic                        enc_err_prev_reg;
    logic                        hist_done;
    logic                        mismatch;
    logic                        speed_mode;
    logic                        nomotor;
    servo_sel_pkg::init_e        state_reg;
    servo_sel_pkg::status_s      status_eff;
    logic                        wr_ctrl;
    logic                        wr_mon;
    logic                        wr_gain;

    assign speed_mode = ctrl_reg[`CTRL_SPEED_BIT];
    assign nomotor    = ctrl_reg[`CTRL_NOMOTOR];
    assign wr_ctrl    = wr_i && addr_i == `OFS_CTRL;
    assign wr_mon     = wr_i && addr_i == `OFS_MONSEL;
    assign wr_gain    = wr_i && addr_i == `OFS_FFGAIN;
    assign mismatch   = ctrl_reg[`CTRL_CABLE_4W] != cable_4wire_i;
    assign hist_done  = state_reg == servo_sel_pkg::ST_ERASE;

    // ==========================================================
    // Power-on initialisation and alarm history clear
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            state_reg <= servo_sel_pkg::ST_INIT;
        end else begin
            case (state_reg)
                servo_sel_pkg::ST_INIT:  state_reg <= hist_clr_stored_i ? servo_sel_pkg::ST_ERASE
                                                                        : servo_sel_pkg::ST_RUN;
                servo_sel_pkg::ST_ERASE: state_reg <= servo_sel_pkg::ST_RUN;
                default:                 state_reg <= servo_sel_pkg::ST_RUN;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            ctrl_reg <= `CTRL_RESET;
        end else if (state_reg == servo_sel_pkg::ST_INIT) begin
            ctrl_reg[`CTRL_HIST_CLR] <= hist_clr_stored_i;
        end else if (hist_done) begin
            ctrl_reg[`CTRL_HIST_CLR] <= 1'b0;
        end else if (wr_ctrl) begin
            ctrl_reg <= wdata_i[5:0];
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            hist_erase_o    <= 1'b0;
            hist_clr_flag_o <= 1'b0;
        end else begin
            hist_erase_o    <= state_reg == servo_sel_pkg::ST_INIT && hist_clr_stored_i;
            hist_clr_flag_o <= ctrl_reg[`CTRL_HIST_CLR];
        end
    end

    // ==========================================================
    // Selector and monitor configuration
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            outsel_reg <= `OUTSEL_RESET;
        end else if (wr_i && addr_i == `OFS_OUTSEL) begin
            outsel_reg <= wdata_i[5:0];
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            mon1_reg <= `MON_RESET;
            mon2_reg <= `MON_RESET;
        end else if (wr_mon) begin
            if (mon_ok(wdata_i[3:0], ctrl_reg[`CTRL_ABS_SYS])) begin
                mon1_reg <= wdata_i[3:0];
            end
            if (mon_ok(wdata_i[7:4], ctrl_reg[`CTRL_ABS_SYS])) begin
                mon2_reg <= wdata_i[7:4];
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            ffgain_reg <= `FFGAIN_RESET;
        end else if (wr_gain && wdata_i[31:0] <= 32'(`FFGAIN_MAX)) begin
            ffgain_reg <= wdata_i[6:0];
        end
    end

    // ==========================================================
    // Motor-less simulation of status and display
    always_comb begin
        status_eff = status_i;
        if (nomotor) begin
            status_eff.zero_speed_flag  = speed_cmd_i == 16'h0000;
            status_eff.in_position_flag = 1'b1;
            status_eff.speed_reached_flag = 1'b1;
            status_eff.abs_position_lost  = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            speed_disp_o <= 16'h0000;
            load_disp_o  <= '0;
        end else begin
            speed_disp_o <= nomotor ? speed_cmd_i : motor_speed_i;
            load_disp_o  <= nomotor ? '0 : load_i;
        end
    end

    // ==========================================================
    // Output pin routing
    always_comb begin
        logic ok;
        ok      = 1'b0;
        sel_val = sel_pick(outsel_reg, speed_mode, status_eff, ok);
        sel_bad = !ok;
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            out_pin_o   <= 1'b0;
            sel_bad_reg <= 1'b0;
        end else begin
            out_pin_o   <= sel_val && !sel_bad && state_reg == servo_sel_pkg::ST_RUN;
            sel_bad_reg <= sel_bad;
        end
    end

    // ==========================================================
    // Home condition and encoder cable check
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            zseen_reg      <= 1'b0;
            home_allowed_o <= 1'b0;
        end else begin
            if (index_pulse_i && state_reg == servo_sel_pkg::ST_RUN) begin
                zseen_reg <= 1'b1;
            end
            home_allowed_o <= state_reg == servo_sel_pkg::ST_RUN
                              && (ctrl_reg[`CTRL_HOME_SEL] || zseen_reg);
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            enc_err1_o       <= 1'b0;
            enc_err2_o       <= 1'b0;
            enc_err_prev_reg <= 1'b0;
        end else begin
            enc_err1_o       <= mismatch && ctrl_reg[`CTRL_CABLE_4W];
            enc_err2_o       <= mismatch && !ctrl_reg[`CTRL_CABLE_4W];
            enc_err_prev_reg <= mismatch;
        end
    end

    // ==========================================================
    // Interrupts
    always_comb begin
        irq_set = '0;
        irq_set[`IRQ_ENC_ERR]   = mismatch && !enc_err_prev_reg;
        irq_set[`IRQ_GAIN_REJ]  = wr_gain && wdata_i[31:0] > 32'(`FFGAIN_MAX);
        irq_set[`IRQ_SEL_BAD]   = sel_bad && !sel_bad_reg;
        irq_set[`IRQ_HIST_DONE] = hist_done;
        irq_set[`IRQ_MON_REJ]   = wr_mon && !(mon_ok(wdata_i[3:0], ctrl_reg[`CTRL_ABS_SYS])
                                  && mon_ok(wdata_i[7:4], ctrl_reg[`CTRL_ABS_SYS]));
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            irq_stat_reg <= '0;
            irq_mask_reg <= '0;
            irq_o        <= 1'b0;
        end else begin
            if (wr_i && addr_i == `OFS_IRQ_STAT) begin
                irq_stat_reg <= (irq_stat_reg & ~wdata_i[4:0]) | irq_set;
            end else begin
                irq_stat_reg <= irq_stat_reg | irq_set;
            end
            if (wr_i && addr_i == `OFS_IRQ_MASK) begin
                irq_mask_reg <= wdata_i[4:0];
            end
            irq_o <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    // ==========================================================
    // Register read
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            rdata_o <= 32'h0000_0000;
        end else if (!rd_i) begin
            rdata_o <= 32'h0000_0000;
        end else if (addr_i == `OFS_CTRL) begin
            rdata_o <= {26'h0, ctrl_reg};
        end else if (addr_i == `OFS_OUTSEL) begin
            rdata_o <= {26'h0, outsel_reg};
        end else if (addr_i == `OFS_MONSEL) begin
            rdata_o <= {24'h0, mon2_reg, mon1_reg};
        end else if (addr_i == `OFS_FFGAIN) begin
            rdata_o <= {25'h0, ffgain_reg};
        end else if (addr_i == `OFS_STATUS) begin
            rdata_o <= {26'h0, enc_err2_o, enc_err1_o, zseen_reg, home_allowed_o, sel_bad_reg, out_pin_o};
        end else if (addr_i == `OFS_ERRCODE) begin
            rdata_o <= {16'h0, enc_err1_o ? `ERR_ENC1 : (enc_err2_o ? `ERR_ENC2 : 16'h0000)};
        end else if (addr_i == `OFS_IRQ_STAT) begin
            rdata_o <= {27'h0, irq_stat_reg};
        end else if (addr_i == `OFS_IRQ_MASK) begin
            rdata_o <= {27'h0, irq_mask_reg};
        end else begin
            rdata_o <= 32'h0000_0000;
        end
    end

    assign mon1_sel_o = mon1_reg;
    assign mon2_sel_o = mon2_reg;
    assign ffgain_o   = ffgain_reg;

    // ==========================================================
    // Assertions
    a_pin_invalid_off: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        sel_bad |=> !out_pin_o) else $error("Invalid selector drove pin");
    a_pin_follows: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        state_reg == servo_sel_pkg::ST_RUN && !sel_bad |=> out_pin_o == $past(sel_val))
        else $error("Pin did not follow selected signal");
    a_mode_inpos: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        outsel_reg == `SEL_INPOS && speed_mode |=> !out_pin_o)
        else $error("In-position routed in speed mode");
    a_mode_speed: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        outsel_reg == `SEL_SPEED && !speed_mode |=> !out_pin_o)
        else $error("Speed reached routed in position mode");
    a_sel_zero_off: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        outsel_reg == `SEL_OFF |=> !out_pin_o) else $error("Code zero not off");
    a_zspd_route: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        state_reg == servo_sel_pkg::ST_RUN && outsel_reg == `SEL_ZSPD
        |=> out_pin_o == $past(status_eff.zero_speed_flag)) else $error("Zero speed misrouted");
    a_hist_flag_clr: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        hist_done |=> !ctrl_reg[`CTRL_HIST_CLR] ##1 !hist_clr_flag_o)
        else $error("History clear flag not reset");
    a_hist_erase_init: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        hist_erase_o |-> $past(state_reg) == servo_sel_pkg::ST_INIT)
        else $error("History erased outside init");
    a_home_needs_z: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        home_allowed_o |-> $past(zseen_reg) || $past(ctrl_reg[`CTRL_HOME_SEL]))
        else $error("Home allowed without index");
    a_enc_err: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        mismatch |=> enc_err1_o || enc_err2_o) else $error("Cable mismatch not reported");
    a_nomotor_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        nomotor |=> load_disp_o == '0) else $error("Load data not zero without motor");
    a_nomotor_speed: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        nomotor |=> speed_disp_o == $past(speed_cmd_i)) else $error("Simulated speed wrong");
    a_mon_range: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        mon1_reg <= `MON_MAX && mon2_reg <= `MON_MAX) else $error("Monitor code out of range");
    a_mon_abs: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        wr_mon && !ctrl_reg[`CTRL_ABS_SYS] && wdata_i[3:0] inside {[`MON_ABS_LO:`MON_ABS_HI]}
        |=> $stable(mon1_reg)) else $error("Position monitor taken without abs system");
    a_gain_range: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        ffgain_reg <= `FFGAIN_MAX) else $error("Feed forward gain above limit");

endmodule

// ### pin_load_model.sv
// External equipment model that watches the selected output pin
module pin_load_model (
    input  wire logic        ref_clk_i,
    input  wire logic        pin_i,
    output logic      [15:0] rise_cnt_o
);
    timeunit 1ns;
    timeprecision 1ns;

    logic        last_reg = 1'b0;
    logic [15:0] cnt_reg  = 16'h0000;

    assign rise_cnt_o = cnt_reg;

    // =====================================
    // Count rising edges seen on the pin
    always @(posedge ref_clk_i) begin
        last_reg <= pin_i;
        if (pin_i && !last_reg) begin
            cnt_reg <= cnt_reg + 16'h0001;
        end
    end
endmodule

// ### test_servo_output_signal_selector.sv
// Self-checking testbench of the output signal selector
`include "servo_sel_map.svh"
module test_servo_output_signal_selector;
    timeunit 1ns;
    timeprecision 1ns;

    logic                   ref_clk_i = 1'b0;
    logic                   rst_n_i = 1'b0;
    logic [7:0]             addr_i = 8'h00;
    logic [31:0]            wdata_i = 32'h0000_0000;
    logic                   wr_i = 1'b0;
    logic                   rd_i = 1'b0;
    logic [31:0]            rdata_o;
    servo_sel_pkg::status_s status_i = '0;
    servo_sel_pkg::load_s   load_i = '0;
    logic [15:0]            motor_speed_i = 16'h0000;
    logic [15:0]            speed_cmd_i = 16'h0000;
    logic                   index_pulse_i = 1'b0;
    logic                   cable_4wire_i = 1'b0;
    logic                   hist_clr_stored_i = 1'b0;
    logic                   out_pin_o;
    logic [3:0]             mon1_sel_o;
    logic [3:0]             mon2_sel_o;
    logic [6:0]             ffgain_o;
    logic                   home_allowed_o;
    logic                   enc_err1_o;
    logic                   enc_err2_o;
    logic                   hist_erase_o;
    logic                   hist_clr_flag_o;
    logic [15:0]            speed_disp_o;
    servo_sel_pkg::load_s   load_disp_o;
    logic                   irq_o;
    logic [15:0]            rise_cnt;
    int                     miscompares = 0;
    int                     total_checks = 0;

    servo_output_signal_selector dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .status_i(status_i),
        .load_i(load_i), .motor_speed_i(motor_speed_i), .speed_cmd_i(speed_cmd_i),
        .index_pulse_i(index_pulse_i), .cable_4wire_i(cable_4wire_i),
        .hist_clr_stored_i(hist_clr_stored_i), .out_pin_o(out_pin_o), .mon1_sel_o(mon1_sel_o),
        .mon2_sel_o(mon2_sel_o), .ffgain_o(ffgain_o), .home_allowed_o(home_allowed_o),
        .enc_err1_o(enc_err1_o), .enc_err2_o(enc_err2_o), .hist_erase_o(hist_erase_o),
        .hist_clr_flag_o(hist_clr_flag_o), .speed_disp_o(speed_disp_o), .load_disp_o(load_disp_o),
        .irq_o(irq_o));
    pin_load_model far_end (.ref_clk_i(ref_clk_i), .pin_i(out_pin_o), .rise_cnt_o(rise_cnt));

    // =====================================
    // Clock and bus helpers
    initial begin
        forever #50 ref_clk_i = ~ref_clk_i;
    end
    task automatic cycles(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        #1;
        chk(rdata_o, exp);
    endtask
    task automatic do_reset(input logic stored);
        int n;
        n = 0;
        @(posedge ref_clk_i);
        hist_clr_stored_i <= stored;
        rst_n_i <= 1'b0;
        repeat (6) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            cycles(1);
            n += int'(hist_erase_o);
        end
        chk(n, stored);
        chk(hist_clr_flag_o, 0);
    endtask
    function automatic int sel_bit(input logic [5:0] c, input logic spd);
        case (c)
            6'h02: return 11;
            6'h03: return 10;
            6'h04: return spd ? -1 : 9;
            6'h05: return 8;
            6'h06: return 7;
            6'h07: return 6;
            6'h08: return 5;
            6'h09: return 4;
            6'h0A: return spd ? 3 : -1;
            6'h0C: return 2;
            6'h0F: return 1;
            6'h11: return spd ? -1 : 0;
            default: return -1;
        endcase
    endfunction

    // =====================================
    // Scenarios
    task automatic t_pin_map();
        int b;
        for (int m = 0; m < 2; m++) begin
            wr(`OFS_CTRL, 32'(m));
            for (int c = 0; c < 64; c++) begin
                b = sel_bit(c[5:0], m[0]);
                wr(`OFS_OUTSEL, 32'(c));
                status_i <= '1;
                cycles(2);
                chk(out_pin_o, b >= 0);
                if (b >= 0) begin
                    @(posedge ref_clk_i);
                    status_i <= servo_sel_pkg::status_s'(~(12'h001 << b));
                    cycles(2);
                    chk(out_pin_o, 0);
                end
            end
        end
        chk(rise_cnt != 16'h0000, 1);
        $display("pin map test finished");
    endtask
    task automatic t_gain_irq();
        wr(`OFS_IRQ_STAT, 32'h0000_001F);
        wr(`OFS_FFGAIN, 32'h0000_0064);
        cycles(1);
        chk(ffgain_o, 7'h64);
        wr(`OFS_FFGAIN, 32'h0000_0065);
        rdc(`OFS_IRQ_STAT, 32'h0000_0002);
        chk(ffgain_o, 7'h64);
        chk(irq_o, 0);
        wr(`OFS_IRQ_MASK, 32'h0000_0002);
        cycles(2);
        chk(irq_o, 1);
        wr(`OFS_IRQ_STAT, 32'h0000_0002);
        cycles(2);
        chk(irq_o, 0);
        $display("gain and interrupt test finished");
    endtask
    task automatic t_monitor();
        wr(`OFS_CTRL, 32'h0000_0000);
        wr(`OFS_MONSEL, 32'h0000_000D);
        cycles(1);
        chk(mon1_sel_o, 4'hD);
        wr(`OFS_MONSEL, 32'h0000_00AE);
        cycles(1);
        chk({mon2_sel_o, mon1_sel_o}, 8'h0D);
        wr(`OFS_CTRL, 32'h0000_0008);
        wr(`OFS_MONSEL, 32'h0000_00CA);
        cycles(1);
        chk({mon2_sel_o, mon1_sel_o}, 8'hCA);
        $display("monitor test finished");
    endtask
    task automatic t_encoder_home();
        wr(`OFS_CTRL, 32'h0000_0000);
        cable_4wire_i <= 1'b1;
        cycles(2);
        chk({enc_err1_o, enc_err2_o}, 2'b01);
        rdc(`OFS_ERRCODE, 32'h0000_2020);
        wr(`OFS_CTRL, 32'h0000_0020);
        cable_4wire_i <= 1'b0;
        cycles(2);
        chk({enc_err1_o, enc_err2_o}, 2'b10);
        rdc(`OFS_ERRCODE, 32'h0000_2016);
        chk(home_allowed_o, 0);
        wr(`OFS_CTRL, 32'h0000_0024);
        cycles(2);
        chk(home_allowed_o, 1);
        wr(`OFS_CTRL, 32'h0000_0020);
        cycles(2);
        chk(home_allowed_o, 0);
        @(posedge ref_clk_i);
        index_pulse_i <= 1'b1;
        @(posedge ref_clk_i);
        index_pulse_i <= 1'b0;
        cycles(2);
        chk(home_allowed_o, 1);
        rdc(`OFS_STATUS, 32'h0000_001E);
        $display("encoder and home test finished");
    endtask
    task automatic t_motorless();
        @(posedge ref_clk_i);
        load_i <= {16'h1234, 16'h5678, 16'h9ABC, 16'hDEF0};
        speed_cmd_i <= 16'h0321;
        motor_speed_i <= 16'h0777;
        status_i <= '0;
        wr(`OFS_CTRL, 32'h0000_0002);
        wr(`OFS_OUTSEL, 32'h0000_0004);
        cycles(2);
        chk(out_pin_o, 1);
        chk(speed_disp_o, 16'h0321);
        chk(load_disp_o, 64'h0);
        $display("motor-less test finished");
    endtask
    task automatic t_history();
        int n;
        n = 0;
        wr(`OFS_CTRL, 32'h0000_0010);
        for (int i = 0; i < 4; i++) begin
            cycles(1);
            n += int'(hist_erase_o);
        end
        chk(n, 0);
        chk(hist_clr_flag_o, 1);
        do_reset(1'b1);
        rdc(`OFS_IRQ_STAT, 32'h0000_0008);
        rdc(`OFS_CTRL, 32'h0000_0000);
        $display("history clear test finished");
    endtask

    // =====================================
    // Verdict and main sequence
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge ref_clk_i);
        miscompares++;
        results();
    end
    initial begin
        do_reset(1'b0);
        chk({out_pin_o, ffgain_o, irq_o}, 9'h000);
        rdc(`OFS_OUTSEL, 32'h0000_0000);
        t_pin_map();
        t_gain_irq();
        t_monitor();
        t_encoder_home();
        t_motorless();
        t_history();
        results();
    end
endmodule
